// File: src/mcsw_map.svh
// bit positions, field widths and register offsets of the machine-check state word block
// assumes inclusion by the package and the design file only
`ifndef MCSW_MAP_SVH
`define MCSW_MAP_SVH
`define MCSW_BIT_MULTI     4
`define MCSW_BIT_INSTEP    6
`define MCSW_BIT_RESUME    7
`define MCSW_BIT_ISOL      8
`define MCSW_BIT_DAMAGE    9
`define MCSW_BIT_VALID_LO  17
`define MCSW_BIT_CORR      18
`define MCSW_BIT_ANTIC     19
`define MCSW_BIT_CREG      20
`define MCSW_BIT_GREG      31
`define MCSW_DSIZE_LO      32
`define MCSW_DSIZE_HI      47
`define MCSW_RSVD_LO       48
`define MCSW_RSVD_HI       58
`define MCSW_SRC_LO        59
`define MCSW_SRC_HI        63
`define MCSW_NVALID        13
`define MCSW_NSRC          5
`define MCSW_NSEV          3
// register word offsets (byte addresses)
`define MCSW_OFS_CTRL      8'h00
`define MCSW_OFS_VALID     8'h04
`define MCSW_OFS_DSIZE     8'h08
`define MCSW_OFS_WORD_LO   8'h0c
`define MCSW_OFS_WORD_HI   8'h10
`define MCSW_OFS_STATUS    8'h14
// control register fields
`define MCSW_CTL_CORR      0
`define MCSW_CTL_ANTIC     1
`define MCSW_CTL_CLEAR     2
// severity codes, most severe highest
`define MCSW_SEV_NONE      3'h0
`define MCSW_SEV_CONT      3'h1
`define MCSW_SEV_NOCONT    3'h2
`define MCSW_SEV_NOCONTAIN 3'h3
`define MCSW_SEV_NOISOL    3'h4
`endif

// File: src/mcsw_pkg.sv
// types of the machine-check state word block
// assumes mcsw_map.svh sits beside it
`include "mcsw_map.svh"
package mcsw_pkg;
  typedef logic [`MCSW_NSEV-1:0] mcsw_sev_t;
  typedef enum logic [1:0] {
    MCSW_IDLE = 2'h1,
    MCSW_ACK  = 2'h2
  } mcsw_bus_t;
endpackage : mcsw_pkg

// File: src/mcsw_state_word.sv
// machine-check state word assembler with a classic wishbone register slave
// assumes one 50 MHz clock, async active-low reset, error reports from core logic on the
// same clock; bits 0..16 other than the recovery and multi-error bits read as zero
//
// Functional notes
// - bit 17 shows stack engine state valid
// - bit 18 shows check already corrected
// - bit 19 shows check was anticipated
// - bits 20-22 control, perf, debug valid
// - bits 23-24 translation entries, region valid
// - bits 25-28 app, jump, qualifier, float valid
// - bits 29-30 upper, lower bank valid
// - bit 31 non-banked general registers only
// - bits 47:32 dynamic state byte count
// - bit 59 cache fault source
// - bit 60 tlb fault source
// - bit 61 bus fault source
// - bit 62 register file fault source
// - bit 63 micro-architecture fault source
// - recovery bits meaningful only when uncorrected
// - only six legal recovery patterns emitted
// - multi-error forces resumable and in-step low
// - damage and isolated follow worst error
// - in-step only with exact instruction pointer
// - recovery bits sit at 6 to 9
// - bit 4 marks distinct multiple errors
`include "mcsw_map.svh"
module mcsw_state_word (
  input  wire logic        clk,
  input  wire logic        rst_b,
  // error report from the core
  input  wire logic        errValid,
  input  wire logic [2:0]  errSeverity,
  input  wire logic [4:0]  errSource,
  input  wire logic        errExactIp,
  // wishbone slave
  input  wire logic        wbCyc,
  input  wire logic        wbStb,
  input  wire logic        wbWe,
  input  wire logic [7:0]  wbAdr,
  input  wire logic [3:0]  wbSel,
  input  wire logic [31:0] wbDatW,
  output logic      [31:0] wbDatR,
  output logic             wbAck,
  // assembled word
  output logic      [63:0] stateWord,
  output logic             wordLive
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic [31:0] mergeSel(input logic [31:0] oldV, input logic [31:0] newV,
                                           input logic [3:0] sel);
    logic [31:0] res;
    res = oldV;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = newV[i*8 +: 8];
      end
    end
    return res;
  endfunction : mergeSel

  function automatic logic [3:0] sevPattern(input mcsw_pkg::mcsw_sev_t sev, input logic exact,
                                            input logic multi);
    logic [3:0] p;
    p = 4'h0;
    unique case (sev)
      `MCSW_SEV_NOISOL:    p = 4'h8;
      `MCSW_SEV_NOCONTAIN: p = 4'hc;
      `MCSW_SEV_NOCONT:    p = 4'h4;
      `MCSW_SEV_CONT:      p = (exact && !multi) ? 4'h7 : 4'h6;
      default:             p = 4'h0;
    endcase
    if (multi && sev == `MCSW_SEV_CONT) begin
      p = 4'h4;
    end
    return p;
  endfunction : sevPattern

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [2:0]                 ctrl_r;
  logic [`MCSW_NVALID-1:0]    valid_r;
  logic [15:0]                dsize_r;
  mcsw_pkg::mcsw_sev_t        worstSev_r;
  logic [`MCSW_NSRC-1:0]      srcFlags_r;
  logic                       exact_r;
  logic                       multi_r;
  logic                       live_r;
  logic [3:0]                 recPat_nxt;
  logic [63:0]                word_nxt;
  mcsw_pkg::mcsw_bus_t        busSt_r;
  logic                       wbReq;
  logic                       wrStrobe;
  logic                       clrReq;
  logic [31:0]                rdData_nxt;
  logic [`MCSW_NSRC-1:0]      newSrc;

  assign wbReq    = wbCyc && wbStb && (busSt_r == mcsw_pkg::MCSW_IDLE);
  assign wrStrobe = wbReq && wbWe;
  assign clrReq   = wrStrobe && wbAdr == `MCSW_OFS_CTRL && wbSel[0]
                    && wbDatW[`MCSW_CTL_CLEAR];
  assign newSrc   = errValid ? errSource : '0;

  // ----------------------------------------------------------------
  // software-written report inputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r  <= '0;
      valid_r <= '0;
      dsize_r <= '0;
    end else if (wrStrobe) begin
      unique case (wbAdr)
        `MCSW_OFS_CTRL:  ctrl_r  <= 3'(mergeSel({29'h0, ctrl_r}, wbDatW, wbSel) & 32'h3);
        `MCSW_OFS_VALID: valid_r <= 13'(mergeSel({19'h0, valid_r}, wbDatW, wbSel));
        `MCSW_OFS_DSIZE: dsize_r <= 16'(mergeSel({16'h0, dsize_r}, wbDatW, wbSel));
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // error accumulation
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      worstSev_r <= `MCSW_SEV_NONE;
      srcFlags_r <= '0;
      exact_r    <= 1'b0;
      multi_r    <= 1'b0;
      live_r     <= 1'b0;
    end else if (errValid) begin
      // a new error wins over a clear in the same cycle
      live_r     <= 1'b1;
      srcFlags_r <= (clrReq ? '0 : srcFlags_r) | newSrc;
      if (clrReq || !live_r) begin
        worstSev_r <= errSeverity;
        exact_r    <= errExactIp;
        multi_r    <= 1'b0;
      end else begin
        if (errSeverity > worstSev_r) begin
          worstSev_r <= errSeverity;
          exact_r    <= errExactIp;
        end
        // a repeat of the same source and severity is not a distinct error
        if (errSource != srcFlags_r || errSeverity != worstSev_r) begin
          multi_r <= 1'b1;
        end
      end
    end else if (clrReq) begin
      worstSev_r <= `MCSW_SEV_NONE;
      srcFlags_r <= '0;
      exact_r    <= 1'b0;
      multi_r    <= 1'b0;
      live_r     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // word assembly
  // ----------------------------------------------------------------
  always_comb begin
    recPat_nxt = sevPattern(worstSev_r, exact_r, multi_r);
    if (ctrl_r[`MCSW_CTL_CORR]) begin
      recPat_nxt = 4'h0;
    end
    word_nxt = '0;
    word_nxt[`MCSW_BIT_MULTI] = multi_r;
    word_nxt[`MCSW_BIT_DAMAGE:`MCSW_BIT_INSTEP] = recPat_nxt;
    word_nxt[`MCSW_BIT_VALID_LO] = valid_r[0];
    word_nxt[`MCSW_BIT_CORR]  = ctrl_r[`MCSW_CTL_CORR];
    word_nxt[`MCSW_BIT_ANTIC] = ctrl_r[`MCSW_CTL_ANTIC];
    word_nxt[`MCSW_BIT_GREG:`MCSW_BIT_CREG] = valid_r[`MCSW_NVALID-1:1];
    word_nxt[`MCSW_DSIZE_HI:`MCSW_DSIZE_LO] = dsize_r;
    word_nxt[`MCSW_SRC_HI:`MCSW_SRC_LO] = srcFlags_r;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stateWord <= '0;
      wordLive  <= 1'b0;
    end else begin
      stateWord <= word_nxt;
      wordLive  <= live_r;
    end
  end

  // ----------------------------------------------------------------
  // wishbone slave: ack one cycle after the request, one wait state
  // ----------------------------------------------------------------
  always_comb begin
    unique case (wbAdr)
      `MCSW_OFS_CTRL:    rdData_nxt = {29'h0, 1'b0, ctrl_r[1:0]};
      `MCSW_OFS_VALID:   rdData_nxt = {19'h0, valid_r};
      `MCSW_OFS_DSIZE:   rdData_nxt = {16'h0, dsize_r};
      `MCSW_OFS_WORD_LO: rdData_nxt = stateWord[31:0];
      `MCSW_OFS_WORD_HI: rdData_nxt = stateWord[63:32];
      `MCSW_OFS_STATUS:  rdData_nxt = {24'h0, multi_r, exact_r, worstSev_r, 1'b0, 1'b0, live_r};
      default:           rdData_nxt = 32'h0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busSt_r <= mcsw_pkg::MCSW_IDLE;
      wbAck   <= 1'b0;
      wbDatR  <= '0;
    end else begin
      unique case (busSt_r)
        mcsw_pkg::MCSW_IDLE: begin
          if (wbReq) begin
            busSt_r <= mcsw_pkg::MCSW_ACK;
            wbAck   <= 1'b1;
            wbDatR  <= wbWe ? 32'h0 : rdData_nxt;
          end
        end
        mcsw_pkg::MCSW_ACK: begin
          busSt_r <= mcsw_pkg::MCSW_IDLE;
          wbAck   <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_b)
    stateWord[`MCSW_RSVD_HI:`MCSW_RSVD_LO] == '0) else $error("reserved bits not zero");

  a_legal_pattern: assert property (@(posedge clk) disable iff (!rst_b)
    !stateWord[`MCSW_BIT_CORR] |-> stateWord[9:6] inside {4'h0, 4'h8, 4'hc, 4'h4, 4'h6, 4'h7})
    else $error("illegal recovery pattern");

  a_multi_clears: assert property (@(posedge clk) disable iff (!rst_b)
    stateWord[`MCSW_BIT_MULTI] |-> stateWord[7:6] == 2'h0) else $error("multi-error with resume");

  a_instep_exact: assert property (@(posedge clk) disable iff (!rst_b)
    stateWord[`MCSW_BIT_INSTEP] |-> $past(exact_r) && stateWord[8:7] == 2'h3)
    else $error("in-step without exact pointer");

  a_corr_follow: assert property (@(posedge clk) disable iff (!rst_b)
    stateWord[`MCSW_BIT_CORR] == $past(ctrl_r[`MCSW_CTL_CORR])) else $error("corrected bit wrong");

  a_dsize_follow: assert property (@(posedge clk) disable iff (!rst_b)
    wrStrobe && wbAdr == `MCSW_OFS_DSIZE && wbSel == 4'hf |-> ##2
    stateWord[`MCSW_DSIZE_HI:`MCSW_DSIZE_LO] == $past(wbDatW[15:0], 2))
    else $error("dynamic size not reported");

  a_src_sticky: assert property (@(posedge clk) disable iff (!rst_b)
    errValid && errSource[0] |-> ##2 stateWord[`MCSW_SRC_LO]) else $error("cache source lost");

  a_ack_pulse: assert property (@(posedge clk) disable iff (!rst_b)
    wbAck |=> !wbAck) else $error("ack longer than one cycle");

  a_worst_damage: assert property (@(posedge clk) disable iff (!rst_b)
    errValid && live_r && !clrReq && errSeverity == `MCSW_SEV_NOISOL |-> ##2
    (stateWord[9:8] == 2'h2 || stateWord[`MCSW_BIT_CORR])) else $error("worst error not kept");

  a_stack_valid: assert property (@(posedge clk) disable iff (!rst_b)
    stateWord[`MCSW_BIT_VALID_LO] == $past(valid_r[0]))
    else $error("stack engine valid bit wrong");

  a_antic_follow: assert property (@(posedge clk) disable iff (!rst_b)
    stateWord[`MCSW_BIT_ANTIC] == $past(ctrl_r[`MCSW_CTL_ANTIC]))
    else $error("anticipated bit wrong");

  a_ctl_valid: assert property (@(posedge clk) disable iff (!rst_b)
    stateWord[22:20] == $past(valid_r[3:1]))
    else $error("control perf debug valid bits wrong");

  a_xlate_valid: assert property (@(posedge clk) disable iff (!rst_b)
    stateWord[24:23] == $past(valid_r[5:4]))
    else $error("translation region valid bits wrong");

  a_app_valid: assert property (@(posedge clk) disable iff (!rst_b)
    stateWord[28:25] == $past(valid_r[9:6]))
    else $error("app jump qualifier float valid bits wrong");

  a_bank_valid: assert property (@(posedge clk) disable iff (!rst_b)
    stateWord[30:29] == $past(valid_r[11:10]))
    else $error("bank valid bits wrong");

  a_greg_valid: assert property (@(posedge clk) disable iff (!rst_b)
    stateWord[`MCSW_BIT_GREG] == $past(valid_r[12]))
    else $error("general register valid bit wrong");

  a_dsize_hold: assert property (@(posedge clk) disable iff (!rst_b)
    stateWord[`MCSW_DSIZE_HI:`MCSW_DSIZE_LO] == $past(dsize_r))
    else $error("dynamic size field wrong");

  a_tlb_sticky: assert property (@(posedge clk) disable iff (!rst_b)
    errValid && errSource[1] |-> ##2 stateWord[60])
    else $error("tlb source lost");

  a_bus_sticky: assert property (@(posedge clk) disable iff (!rst_b)
    errValid && errSource[2] |-> ##2 stateWord[61])
    else $error("bus source lost");

  a_regf_sticky: assert property (@(posedge clk) disable iff (!rst_b)
    errValid && errSource[3] |-> ##2 stateWord[62])
    else $error("register file source lost");

  a_uarch_sticky: assert property (@(posedge clk) disable iff (!rst_b)
    errValid && errSource[4] |-> ##2 stateWord[`MCSW_SRC_HI])
    else $error("micro-architecture source lost");

  a_corr_masks: assert property (@(posedge clk) disable iff (!rst_b)
    stateWord[`MCSW_BIT_CORR] |-> stateWord[`MCSW_BIT_DAMAGE:`MCSW_BIT_INSTEP] == 4'h0)
    else $error("recovery bits shown while corrected");

  a_multi_follow: assert property (@(posedge clk) disable iff (!rst_b)
    stateWord[`MCSW_BIT_MULTI] == $past(multi_r))
    else $error("multi-error bit wrong");

  a_repeat_single: assert property (@(posedge clk) disable iff (!rst_b)
    errValid && live_r && !clrReq && !multi_r && errSource == srcFlags_r
    && errSeverity == worstSev_r |=> !multi_r) else $error("repeat counted as distinct");

  a_distinct_multi: assert property (@(posedge clk) disable iff (!rst_b)
    errValid && live_r && !clrReq && errSource != srcFlags_r |=> multi_r)
    else $error("distinct error not flagged");

  a_clear_idle: assert property (@(posedge clk) disable iff (!rst_b)
    clrReq && !errValid |=> !live_r && worstSev_r == `MCSW_SEV_NONE)
    else $error("clear did not drop held error");

  a_src_clear: assert property (@(posedge clk) disable iff (!rst_b)
    clrReq && !errValid |=> srcFlags_r == '0)
    else $error("clear did not drop sources");

  a_worst_rise: assert property (@(posedge clk) disable iff (!rst_b)
    errValid && live_r && !clrReq && errSeverity > worstSev_r |=> worstSev_r == $past(errSeverity))
    else $error("worse error not taken");

  a_exact_first: assert property (@(posedge clk) disable iff (!rst_b)
    errValid && (clrReq || !live_r) |=> exact_r == $past(errExactIp) && !multi_r)
    else $error("first error pointer not taken");

  a_first_sev: assert property (@(posedge clk) disable iff (!rst_b)
    errValid && (clrReq || !live_r) |=> worstSev_r == $past(errSeverity))
    else $error("first error severity not taken");

  a_damage_noresume: assert property (@(posedge clk) disable iff (!rst_b)
    stateWord[`MCSW_BIT_DAMAGE] |-> stateWord[`MCSW_BIT_RESUME:`MCSW_BIT_INSTEP] == 2'h0)
    else $error("damage with resume bits");

  a_resume_isol: assert property (@(posedge clk) disable iff (!rst_b)
    stateWord[`MCSW_BIT_RESUME] |-> stateWord[`MCSW_BIT_ISOL] && !stateWord[`MCSW_BIT_DAMAGE])
    else $error("resumable without isolation");

  a_nonisol_damage: assert property (@(posedge clk) disable iff (!rst_b)
    !stateWord[`MCSW_BIT_ISOL] && stateWord[9:6] != 4'h0 |-> stateWord[`MCSW_BIT_DAMAGE])
    else $error("non-isolated error without damage");

  a_live_follow: assert property (@(posedge clk) disable iff (!rst_b)
    wordLive == $past(live_r))
    else $error("live flag wrong");

  a_ack_after_req: assert property (@(posedge clk) disable iff (!rst_b)
    wbReq |=> wbAck && busSt_r == mcsw_pkg::MCSW_ACK)
    else $error("request not acknowledged");

  a_read_hi: assert property (@(posedge clk) disable iff (!rst_b)
    wbReq && !wbWe && wbAdr == `MCSW_OFS_WORD_HI |=> wbDatR == $past(stateWord[63:32]))
    else $error("upper word read wrong");

  a_write_data_zero: assert property (@(posedge clk) disable iff (!rst_b)
    wbReq && wbWe |=> wbDatR == '0)
    else $error("write returned data");

endmodule : mcsw_state_word

// File: dv/mcsw_state_word_tb.sv
// self-checking bench of the machine-check state word block
// assumes the design files under src/, one 50 MHz clock and a classic wishbone master here
module mcsw_state_word_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk;
  logic        rst_b;
  logic        errValid;
  logic [2:0]  errSeverity;
  logic [4:0]  errSource;
  logic        errExactIp;
  logic        wbCyc;
  logic        wbStb;
  logic        wbWe;
  logic [7:0]  wbAdr;
  logic [3:0]  wbSel;
  logic [31:0] wbDatW;
  logic [31:0] wbDatR;
  logic        wbAck;
  logic [63:0] stateWord;
  logic        wordLive;
  logic [31:0] rdQ;
  logic [31:0] rdH;
  int          err_total;
  int          n_tests;

  mcsw_state_word dut_u (.clk(clk), .rst_b(rst_b), .errValid(errValid),
    .errSeverity(errSeverity), .errSource(errSource), .errExactIp(errExactIp),
    .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel),
    .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck), .stateWord(stateWord),
    .wordLive(wordLive));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task print_verdict;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("unexpected t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // one classic cycle; ack and read data are taken at the rising edge where ack is high
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    @(posedge clk);
    wbCyc  <= 1'b1;
    wbStb  <= 1'b1;
    wbWe   <= we;
    wbAdr  <= a;
    wbSel  <= 4'hf;
    wbDatW <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    if (wbAck !== 1'b1) begin
      err_total++;
      print_verdict();
    end
    q = wbDatR;
    wbCyc  <= 1'b0;
    wbStb  <= 1'b0;
    wbWe   <= 1'b0;
    wbDatW <= 32'h0;
  endtask : wb

  // waits out the two-edge path into the state word
  task automatic settle;
    @(posedge clk);
    @(negedge clk);
  endtask : settle

  task automatic err(input logic [2:0] s, input logic [4:0] src, input logic x);
    @(posedge clk);
    errValid    <= 1'b1;
    errSeverity <= s;
    errSource   <= src;
    errExactIp  <= x;
    @(posedge clk);
    errValid    <= 1'b0;
    settle();
  endtask : err

  task automatic clr;
    wb(1'b1, 8'h00, 32'h4, rdQ);
    settle();
  endtask : clr

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_valid;
    for (int i = 0; i < 13; i++) begin
      wb(1'b1, 8'h04, 32'h1 << i, rdQ);
      settle();
      chk(stateWord, (i == 0) ? 64'h1 << 17 : 64'h1 << (19 + i));
    end
    wb(1'b1, 8'h04, 32'h0, rdQ);
    wb(1'b1, 8'h00, 32'h3, rdQ);
    settle();
    chk(stateWord, 64'hc0000);
    wb(1'b1, 8'h00, 32'h0, rdQ);
    wb(1'b1, 8'h08, 32'hffffbeef, rdQ);
    settle();
    chk(stateWord, 64'hbeef_0000_0000);
    wb(1'b1, 8'h08, 32'h0, rdQ);
  endtask : t_valid

  task automatic t_src;
    for (int i = 0; i < 5; i++) begin
      clr();
      err(3'h2, 5'h1 << i, 1'b0);
      chk(stateWord, (64'h1 << (59 + i)) | 64'h100);
      chk({63'h0, wordLive}, 64'h1);
    end
  endtask : t_src

  task automatic t_sev;
    logic [2:0] sv [5] = '{3'h1, 3'h1, 3'h2, 3'h3, 3'h4};
    logic       xp [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
    logic [3:0] pt [5] = '{4'h7, 4'h6, 4'h4, 4'hc, 4'h8};
    for (int k = 0; k < 5; k++) begin
      clr();
      err(sv[k], 5'h1, xp[k]);
      chk(stateWord, (64'h1 << 59) | (64'(pt[k]) << 6));
    end
  endtask : t_sev

  task automatic t_multi;
    clr();
    err(3'h1, 5'h1, 1'b1);
    err(3'h1, 5'h1, 1'b1);
    chk(64'(stateWord[9:4]), 64'h1c);
    err(3'h3, 5'h2, 1'b1);
    chk(64'(stateWord[9:4]), 64'h31);
    err(3'h1, 5'h1, 1'b1);
    chk(64'(stateWord[9:4]), 64'h31);
    wb(1'b1, 8'h00, 32'h1, rdQ);
    settle();
    chk(64'({stateWord[18], stateWord[9:6]}), 64'h10);
    wb(1'b1, 8'h00, 32'h0, rdQ);
    clr();
    err(3'h1, 5'h1, 1'b1);
    err(3'h1, 5'h2, 1'b1);
    chk(64'(stateWord[9:4]), 64'h11);
  endtask : t_multi

  // software answers damage by resetting the system
  task automatic t_reset;
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    chk(stateWord, 64'h0);
    chk({63'h0, wordLive}, 64'h0);
    wb(1'b0, 8'h10, 32'h0, rdQ);
    chk(64'(rdQ), 64'h0);
  endtask : t_reset

  task automatic t_bus;
    logic [63:0] e;
    e = 64'h8000_1234_fff2_0200;
    clr();
    wb(1'b1, 8'h04, 32'h1fff, rdQ);
    wb(1'b1, 8'h08, 32'h1234, rdQ);
    err(3'h4, 5'h10, 1'b0);
    chk(stateWord, e);
    wb(1'b0, 8'h0c, 32'h0, rdQ);
    wb(1'b0, 8'h10, 32'h0, rdH);
    chk({rdH, rdQ}, e);
    wb(1'b0, 8'h20, 32'h0, rdQ);
    chk(64'(rdQ), 64'h0);
  endtask : t_bus

  // ----------------------------------------
  // clock, reset and main sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    err_total = 0;
    n_tests = 0;
    rst_b = 1'b0;
    {errValid, errSeverity, errSource, errExactIp} = '0;
    {wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatW} = '0;
    repeat (10) @(posedge clk);
    @(negedge clk);
    chk({stateWord[63:1], wordLive}, 64'h0);
    @(posedge clk);
    rst_b <= 1'b1;
    t_valid();
    t_src();
    t_sev();
    t_multi();
    t_bus();
    t_reset();
    print_verdict();
  end
endmodule : mcsw_state_word_tb
